// ==== cri_checker.sv ====
module cri_checker (
    input wire       sys_clk,
    input wire       reset,
    input wire [7:0] regAddr,
    input wire       regWrite,
    input wire [7:0] regWdata,
    input wire       cmdIssue_reg,
    input wire [7:0] cmdCode_reg,
    input wire       wakeRequest_reg,
    input wire       seqDone,
    input wire       seqError,
    input wire [2:0] proxEvent,
    input wire [5:0] irqEnable,
    input wire       intActive,
    input wire       errorHeld
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    sequence s_mbox_wr;
        regWrite && regAddr == 8'h18;
    endsequence
    sequence s_clear_wr;
        s_mbox_wr ##0 regWdata <= 8'h01;
    endsequence
    chk_err_sets: assert property (seqError |=> errorHeld)
        else $error("error code without top bit");
    chk_err_keep: assert property (errorHeld && !(regWrite && (regAddr ==
        8'h20 || (regAddr == 8'h18 && regWdata <= 8'h01))) |=> errorHeld)
        else $error("error code lost");
    chk_err_clear: assert property (errorHeld ##0 s_clear_wr ##0 !seqError
        |=> !errorHeld)
        else $error("clear command did not clear error");
    chk_cmd_drop: assert property (errorHeld ##0 s_mbox_wr ##0
        regWdata > 8'h01 |=> !cmdIssue_reg)
        else $error("command issued while error held");
    chk_cmd_take: assert property (!errorHeld ##0 s_mbox_wr |=>
        cmdIssue_reg && cmdCode_reg == $past(regWdata))
        else $error("command not handed on");
    chk_wake_pulse: assert property (s_mbox_wr |=> wakeRequest_reg)
        else $error("no wake on mailbox write");
    chk_done_irq: assert property (seqDone && !seqError && !errorHeld &&
        irqEnable[5] |=> intActive)
        else $error("command flag did not raise interrupt");
    chk_prox_irq: assert property ((proxEvent & irqEnable[4:2]) != 3'h0
        |=> intActive)
        else $error("proximity flag did not raise interrupt");
    chk_irq_off: assert property (irqEnable == 6'h00 |=> !intActive)
        else $error("interrupt with all enables off");
endmodule
bind cri_command_result cri_checker chk_u (.sys_clk, .reset, .regAddr,
    .regWrite, .regWdata, .cmdIssue_reg, .cmdCode_reg, .wakeRequest_reg,
    .seqDone, .seqError, .proxEvent, .irqEnable, .intActive, .errorHeld);

// ==== cri_command_result.v ====
`include "cri_regs.vh"

// Functional notes
// - On a sequencer error, result register takes an error code with top bit set.
// - Error code stays until a reset or no-operation command, or a host write to the result register, arrives.
// - While an error is held, all other commands are dropped.
// - Autonomous measurements keep running and flagging while an error is held.
// - Values 0x00-0x0F mean no error; low four bits are a counter.
// - Each executed command bumps the 4-bit counter, wrapping fifteen to zero.
// - Proximity one, two, three overflow give codes 0x88, 0x89, 0x8A.
// - Visible, infrared, auxiliary overflow give codes 0x8C, 0x8D, 0x8E.
// - Flags: 7:6 reserved, 5 command, 4..2 proximity three..one, 1:0 light.
// - Interrupt output active when any flag is set with its enable set.
// - Flags read zero after reset.
// - Commands enter through the mailbox; writing it wakes the device.
module cri_command_result (
    // Clock and reset
    input  wire       sys_clk,
    input  wire       reset,
    // Register access from the serial interface
    input  wire [7:0] regAddr,
    input  wire       regWrite,
    input  wire       regRead,
    input  wire [7:0] regWdata,
    output reg  [7:0] regRdata_reg,
    output wire       regHit,
    // Command handed to the sequencer
    output reg        cmdIssue_reg,
    output reg  [7:0] cmdCode_reg,
    output reg        wakeRequest_reg,
    // Sequencer status
    input  wire       seqDone,
    input  wire       seqError,
    input  wire [2:0] seqErrorSource,
    // Autonomous measurement events
    input  wire [2:0] proxEvent,
    input  wire [1:0] ambientEvent,
    // Interrupt
    input  wire [5:0] irqEnable,
    output wire       intActive,
    output wire       errorHeld
);

    reg  [7:0] result_reg;
    reg  [7:0] result_next;
    reg  [7:0] mailbox_reg;
    wire [7:0] flagsValue;
    wire       mailboxWrite;
    wire       resultWrite;
    wire       flagsWrite;
    wire       clearCmd;
    wire       cmdAccept;
    wire       cmdComplete;

    // Map an overflow source to its result code
    function [7:0] errorCode;
        input [2:0] src;
        begin
            case (src)
                `CRI_SRC_PROX_ONE:   errorCode = `CRI_ERR_PROX_ONE;
                `CRI_SRC_PROX_TWO:   errorCode = `CRI_ERR_PROX_TWO;
                `CRI_SRC_PROX_THREE: errorCode = `CRI_ERR_PROX_THREE;
                `CRI_SRC_VISIBLE:    errorCode = `CRI_ERR_VISIBLE;
                `CRI_SRC_INFRARED:   errorCode = `CRI_ERR_INFRARED;
                `CRI_SRC_AUX:        errorCode = `CRI_ERR_AUX;
                default:             errorCode = `CRI_ERR_GENERIC;
            endcase
        end
    endfunction

    // Address decode, used for writes, reads and the hit flag
    function isAddr;
        input [7:0] addr;
        input [7:0] target;
        begin
            isAddr = (addr == target);
        end
    endfunction

    assign mailboxWrite = regWrite && isAddr(regAddr, `CRI_MAILBOX_ADDR);
    assign resultWrite  = regWrite && isAddr(regAddr, `CRI_RESULT_ADDR);
    assign flagsWrite   = regWrite && isAddr(regAddr, `CRI_FLAGS_ADDR);
    assign regHit       = isAddr(regAddr, `CRI_MAILBOX_ADDR)
                        | isAddr(regAddr, `CRI_RESULT_ADDR)
                        | isAddr(regAddr, `CRI_FLAGS_ADDR);

    assign errorHeld = result_reg[`CRI_RESULT_ERR_BIT];

    // Reset and no-operation commands are let through even during an error
    assign clearCmd  = (regWdata == `CRI_CMD_IDLE)
                     | (regWdata == `CRI_CMD_RESET);
    assign cmdAccept = mailboxWrite && (!errorHeld || clearCmd);

    // A completion counts only when no error is reported in the same cycle
    assign cmdComplete = seqDone && !seqError;

    // Result register next value; errors take priority over the counter
    always @* begin
        result_next = result_reg;
        if (seqError) begin
            result_next = errorCode(seqErrorSource);
        end else if (mailboxWrite && errorHeld && clearCmd) begin
            result_next = `CRI_RESULT_RESET;
        end else if (resultWrite) begin
            result_next = regWdata;
        end else if (cmdComplete && !errorHeld) begin
            result_next[7:4] = 4'h0;
            if (result_reg[`CRI_COUNT_MSB:`CRI_COUNT_LSB] ==
                    `CRI_COUNT_WRAP) begin
                result_next[3:0] = 4'h0;
            end else begin
                result_next[3:0] = result_reg[3:0] + 4'h1;
            end
        end
    end

    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            result_reg <= `CRI_RESULT_RESET;
        end else begin
            result_reg <= result_next;
        end
    end

    // Mailbox and hand-off to the sequencer
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            mailbox_reg     <= `CRI_MAILBOX_RESET;
            cmdIssue_reg    <= 1'b0;
            cmdCode_reg     <= `CRI_MAILBOX_RESET;
            wakeRequest_reg <= 1'b0;
        end else begin
            cmdIssue_reg    <= cmdAccept;
            wakeRequest_reg <= mailboxWrite;
            if (mailboxWrite) begin
                mailbox_reg <= regWdata;
            end
            if (cmdAccept) begin
                cmdCode_reg <= regWdata;
            end
        end
    end

    // Read data, one cycle after the read strobe
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            regRdata_reg <= 8'h00;
        end else if (regRead) begin
            case (1'b1)
                isAddr(regAddr, `CRI_MAILBOX_ADDR): regRdata_reg <= mailbox_reg;
                isAddr(regAddr, `CRI_RESULT_ADDR):  regRdata_reg <= result_reg;
                isAddr(regAddr, `CRI_FLAGS_ADDR):   regRdata_reg <= flagsValue;
                default:                            regRdata_reg <= 8'h00;
            endcase
        end
    end

    // Measurement flags are not gated by a held error
    cri_event_flags u_flags (
        .sys_clk       (sys_clk),
        .reset         (reset),
        .cmdSet        (cmdComplete && !errorHeld),
        .proxSet       (proxEvent),
        .ambientSet    (ambientEvent),
        .flagWrite     (flagsWrite),
        .flagWdata     (regWdata),
        .irqEnable     (irqEnable),
        .flags_reg     (flagsValue),
        .intActive_reg (intActive)
    );

endmodule

// ==== cri_event_flags.v ====
`include "cri_regs.vh"

module cri_event_flags (
    // Clock and reset
    input  wire       sys_clk,
    input  wire       reset,
    // Hardware set requests, one-cycle pulses
    input  wire       cmdSet,
    input  wire [2:0] proxSet,
    input  wire [1:0] ambientSet,
    // Host write, ones clear
    input  wire       flagWrite,
    input  wire [7:0] flagWdata,
    // Enables and outputs
    input  wire [5:0] irqEnable,
    output reg  [7:0] flags_reg,
    output reg        intActive_reg
);

    reg  [7:0] flags_next;
    wire [7:0] setMask;
    wire [7:0] clrMask;

    assign setMask = {2'b00, cmdSet, proxSet[2], proxSet[1], proxSet[0],
                      ambientSet};
    assign clrMask = flagWrite ? flagWdata : 8'h00;

    // Set wins over a clear in the same cycle; top bits stay zero
    always @* begin
        flags_next = ((flags_reg & ~clrMask) | setMask)
                     & `CRI_FLAG_USED_MASK;
    end

    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            flags_reg     <= `CRI_FLAGS_RESET;
            intActive_reg <= 1'b0;
        end else begin
            flags_reg     <= flags_next;
            intActive_reg <= |(flags_next[5:0] & irqEnable);
        end
    end

endmodule

// ==== cri_regs.vh ====
`ifndef CRI_REGS_VH
`define CRI_REGS_VH

// Register offsets on the serial register interface
`define CRI_MAILBOX_ADDR     8'h18
`define CRI_RESULT_ADDR      8'h20
`define CRI_FLAGS_ADDR       8'h21

// Reset values
`define CRI_RESULT_RESET     8'h00
`define CRI_FLAGS_RESET      8'h00
`define CRI_MAILBOX_RESET    8'h00

// Command result layout
`define CRI_RESULT_ERR_BIT   7
`define CRI_COUNT_MSB        3
`define CRI_COUNT_LSB        0
`define CRI_COUNT_WRAP       4'hF

// Error codes: converter overflow per channel, generic code for any other source
`define CRI_ERR_PROX_ONE     8'h88
`define CRI_ERR_PROX_TWO     8'h89
`define CRI_ERR_PROX_THREE   8'h8A
`define CRI_ERR_VISIBLE      8'h8C
`define CRI_ERR_INFRARED     8'h8D
`define CRI_ERR_AUX          8'h8E
`define CRI_ERR_GENERIC      8'h80

// Overflow source selectors from the sequencer
`define CRI_SRC_PROX_ONE     3'h0
`define CRI_SRC_PROX_TWO     3'h1
`define CRI_SRC_PROX_THREE   3'h2
`define CRI_SRC_VISIBLE      3'h4
`define CRI_SRC_INFRARED     3'h5
`define CRI_SRC_AUX          3'h6

// Command codes always accepted while an error is held
`define CRI_CMD_IDLE         8'h00
`define CRI_CMD_RESET        8'h01

// Event flag layout
`define CRI_FLAG_CMD_BIT     5
`define CRI_FLAG_PROX3_BIT   4
`define CRI_FLAG_PROX2_BIT   3
`define CRI_FLAG_PROX1_BIT   2
`define CRI_FLAG_ALS_MSB     1
`define CRI_FLAG_ALS_LSB     0
`define CRI_FLAG_USED_MASK   8'h3F

`endif

// ==== cri_seq_model.sv ====
module cri_seq_model (
    // Clock and reset
    input  wire       sys_clk,
    input  wire       reset,
    // Command from the block, failure steering from the bench
    input  wire       cmdIssue,
    input  wire       failMode,
    input  wire [2:0] failSource,
    // Completion status back to the block
    output reg        seqDone,
    output reg        seqError,
    output reg  [2:0] seqErrorSource
);
    timeunit 1ns;
    timeprecision 1ps;
    reg [1:0] pend;
    // Finishes each command three cycles after the issue; the source line wanders when idle
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            pend <= 2'b00;
            seqDone <= 1'b0;
            seqError <= 1'b0;
            seqErrorSource <= 3'h7;
        end else begin
            pend <= {pend[0], cmdIssue};
            seqDone <= pend[1] && !failMode;
            seqError <= pend[1] && failMode;
            seqErrorSource <= pend[1] ? failSource : ~seqErrorSource;
        end
    end
endmodule

// ==== tb_top.sv ====
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    reg        sys_clk, reset, regWrite, regRead, failMode;
    reg  [7:0] regAddr, regWdata, src;
    reg  [2:0] proxEvent, failSource;
    reg  [1:0] ambientEvent;
    reg  [5:0] irqEnable;
    wire [7:0] regRdata;
    wire [2:0] seqErrorSource;
    wire       cmdIssue, seqDone, seqError, intActive, errorHeld;
    integer    errTotal, cmpCount, i;
    cri_command_result dut_u (.sys_clk, .reset, .regAddr, .regWrite,
        .regRead, .regWdata, .regRdata_reg(regRdata), .regHit(),
        .cmdIssue_reg(cmdIssue), .cmdCode_reg(), .wakeRequest_reg(),
        .seqDone, .seqError, .seqErrorSource, .proxEvent, .ambientEvent,
        .irqEnable, .intActive, .errorHeld);
    cri_seq_model seq_u (.sys_clk, .reset, .cmdIssue, .failMode,
        .failSource, .seqDone, .seqError, .seqErrorSource);
    always #2 sys_clk = ~sys_clk;
    task finalReport;
        begin
            if (errTotal == 0 && cmpCount > 0) begin
                $display("DONE - PASS");
            end else begin
                $display("DONE - FAIL");
            end
            $finish;
        end
    endtask
    task peek(input [7:0] a);
        begin
            @(negedge sys_clk) regAddr = a;
            regRead = 1'b1;
            @(negedge sys_clk) regRead = 1'b0;
        end
    endtask
    task rd(input [7:0] a, input [7:0] e);
        begin
            peek(a);
            cmpCount = cmpCount + 1;
            if (regRdata !== e) begin
                errTotal = errTotal + 1;
                $display("unexpected reg %h exp %h got %h", a, e, regRdata);
            end
        end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        begin
            @(negedge sys_clk) regAddr = a;
            regWdata = d;
            regWrite = 1'b1;
            @(negedge sys_clk) regWrite = 1'b0;
        end
    endtask
    // Host confirms execution by watching the result register
    task pollResult(input [7:0] e);
        integer n;
        begin
            peek(8'h20);
            for (n = 0; n < 20 && regRdata !== e; n = n + 1) begin
                peek(8'h20);
            end
            cmpCount = cmpCount + 1;
            if (regRdata !== e) begin
                errTotal = errTotal + 1;
                $display("unexpected result exp %h got %h", e, regRdata);
                finalReport;
            end
        end
    endtask
    initial begin
        {sys_clk, regWrite, regRead, failMode, regAddr, regWdata} = 0;
        {proxEvent, failSource, ambientEvent, irqEnable} = 0;
        {errTotal, cmpCount} = 0;
        reset = 1'b1;
        repeat (8) @(posedge sys_clk);
        @(negedge sys_clk) reset = 1'b0;
        rd(8'h20, 8'h00);
        rd(8'h21, 8'h00);
        rd(8'h55, 8'h00);
        irqEnable = 6'h3F;
        for (i = 1; i <= 17; i = i + 1) begin
            wr(8'h18, 8'h02);
            pollResult(i[7:0] & 8'h0F);
        end
        rd(8'h21, 8'h20);
        cmpCount = cmpCount + 1;
        if (intActive !== 1'b1) begin
            errTotal = errTotal + 1;
            $display("unexpected intActive exp 1 got %b", intActive);
        end
        for (i = 0; i < 6; i = i + 1) begin
            src = i + (i > 2);
            wr(8'h21, 8'h3F);
            failMode = 1'b1;
            failSource = src[2:0];
            wr(8'h18, 8'h02);
            pollResult(8'h88 + src);
            failMode = 1'b0;
            wr(8'h18, 8'h03);
            @(negedge sys_clk) proxEvent = 3'h1 << (i % 3);
            ambientEvent = 2'h3;
            @(negedge sys_clk) proxEvent = 3'h0;
            ambientEvent = 2'h0;
            rd(8'h20, 8'h88 + src);
            cmpCount = cmpCount + 1;
            if (errorHeld !== 1'b1) begin
                errTotal = errTotal + 1;
                $display("unexpected errorHeld exp 1 got %b", errorHeld);
            end
            rd(8'h21, (8'h04 << (i % 3)) | 8'h03);
            wr(8'h18, {7'h00, i[0]});
            pollResult(8'h01);
        end
        finalReport;
    end
endmodule
